// >>> design/pcb_pkg.sv
// Purpose: shared constants for the proximity card block protocol engine
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   offsets are byte addresses
package pcb_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_RXBLK   = 8'h04;
  localparam logic [7:0] OFS_REPLY   = 8'h08;
  localparam logic [7:0] OFS_TXCHAIN = 8'h0C;
  localparam logic [7:0] OFS_SW      = 8'h10;
  localparam logic [7:0] OFS_REQB    = 8'h14;
  localparam logic [7:0] OFS_SYSAFI  = 8'h18;
  localparam logic [7:0] OFS_SIA_LO  = 8'h1C;
  localparam logic [7:0] OFS_SIA_HI  = 8'h20;
  localparam logic [7:0] OFS_PUPI    = 8'h24;
  localparam logic [7:0] OFS_STATUS  = 8'h28;

  // ==========================================================
  // field positions
  localparam int CTRL_ACTIVATE = 0;
  localparam int CTRL_FIELDOFF = 1;
  localparam int CTRL_RPLY_CLR = 2;
  localparam int RX_TYPE_LSB   = 0;
  localparam int RX_TYPE_W     = 3;
  localparam int RX_BN         = 4;
  localparam int RX_CHAIN      = 5;
  localparam int RP_BN         = 4;
  localparam int RP_CHAIN      = 5;
  localparam int RP_VALID      = 8;
  localparam int SW2_LSB       = 0;
  localparam int SW1_LSB       = 8;
  localparam int ST_BN         = 0;
  localparam int ST_RXCHAIN    = 1;
  localparam int ST_TXCHAIN    = 2;
  localparam int ST_STATE_LSB  = 4;

  // ==========================================================
  // received block kinds
  typedef enum logic [2:0] {
    RX_IBLK    = 3'h0,
    RX_RACK    = 3'h1,
    RX_RNAK    = 3'h2,
    RX_SDESEL  = 3'h3,
    RX_INVALID = 3'h4,
    RX_TIMEOUT = 3'h5
  } pcb_rx_e;

  // reply block kinds; waiting-time extension has no code
  typedef enum logic [2:0] {
    RP_NONE   = 3'h0,
    RP_IBLK   = 3'h1,
    RP_RACK   = 3'h2,
    RP_RNAK   = 3'h3,
    RP_SDESEL = 3'h4
  } pcb_rp_e;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_DESEL  = 2'b11
  } pcb_state_e;

  // ==========================================================
  // reset values and misc
  localparam logic       BN_INIT     = 1'b1;
  localparam logic [7:0] AFI_ANY     = 8'h00;
  localparam logic [3:0] NIB_ZERO    = 4'h0;
  localparam logic [1:0] HTRANS_NSEQ = 2'b10;
  localparam logic [7:0] SYSAFI_RST  = 8'h00;
  localparam logic [15:0] SW_RST     = 16'h9000;

endpackage : pcb_pkg

// >>> design/pcb_sys_if.sv
// Purpose: carries system-area values and the REQB family check
// Assumes: one owner (top) and one matcher
// Notes:   none
`timescale 1ns/1ps
interface pcb_sys_if;
  logic [7:0]  sys_afi;
  logic [63:0] sia;
  logic [7:0]  reqb_afi;
  logic        afi_match;
  logic [31:0] pupi;

  modport owner   (output sys_afi, output sia, output reqb_afi,
                   input afi_match, input pupi);
  modport matcher (input sys_afi, input sia, input reqb_afi,
                   output afi_match, output pupi);
endinterface : pcb_sys_if

// >>> design/pcb_afi_match.sv
// Purpose: REQB family filter and identifier extraction
// Assumes: inputs are registers on hclk
// Notes:   outputs registered
`timescale 1ns/1ps
module pcb_afi_match (
  input wire logic  hclk,
  input wire logic  hresetn,
  pcb_sys_if.matcher sys
);

  logic [3:0] req_hi;
  logic [3:0] req_lo;
  logic       match_d;
  logic       match_q;
  logic [31:0] pupi_q;

  assign req_hi = sys.reqb_afi[7:4];
  assign req_lo = sys.reqb_afi[3:0];

  // ==========================================================
  // family decision
  always_comb begin
    if (sys.reqb_afi == pcb_pkg::AFI_ANY) begin
      match_d = 1'b1;
    end else if (req_lo == pcb_pkg::NIB_ZERO) begin
      match_d = (req_hi == sys.sys_afi[7:4]);
    end else if (req_hi == pcb_pkg::NIB_ZERO) begin
      match_d = (req_lo == sys.sys_afi[3:0]);
    end else begin
      match_d = (sys.reqb_afi == sys.sys_afi);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_q <= 1'b0;
    end else begin
      match_q <= match_d;
    end
  end

  // ==========================================================
  // identifier from low four bytes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pupi_q <= 32'h0000_0000;
    end else begin
      pupi_q <= sys.sia[31:0];
    end
  end

  assign sys.afi_match = match_q;
  assign sys.pupi      = pupi_q;

endmodule : pcb_afi_match

// >>> design/pcb_block_proto.sv
// Purpose: card-side block protocol engine with AHB-Lite registers
// Assumes: software writes each received block descriptor, reads reply
// Notes:   zero wait-state slave, response always OKAY
//
// Behaviour
// - Reader opens every exchange; card replies only to a received block.
// - Received I-block with chaining set is acknowledged with R(ACK).
// - S-blocks come in pairs; card answers an S(DESELECT) only if it is received while active.
// - Invalid block or timeout gives R(NAK), except chaining or deselected.
// - Invalid block or timeout while chaining gives R(ACK).
// - Card never sends S(WTX) instead of I-block or R(ACK).
// - R(ACK) or R(NAK) with equal number makes card resend last I-block.
// - R(NAK) with different number makes card reply R(ACK).
// - Chaining card sends next chained I-block on R(ACK) with other number.
// - Command and response APDUs live wholly in the information field.
// - Response APDU is optional data then status word one, then two.
// - Card family value comes from the stored system area field.
// - REQB family zero is answered whatever the stored value.
// - One zero nibble: answer only if the nonzero nibble matches.
// - Other family values: answer only on whole-byte match.
// - Identifier is low four bytes of the stored identification area.
// - Card block number set to one at each activation.
// - Card toggles block number on receiving an I-block before replying.
// - Toggle on R(ACK) with other number; keep it on R(NAK).
`timescale 1ns/1ps
module pcb_block_proto (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output      logic        hreadyout,
  output      logic        hresp,
  output      logic [31:0] hrdata
);

  pcb_sys_if sys ();

  pcb_afi_match u_match (
    .hclk    (hclk),
    .hresetn (hresetn),
    .sys     (sys.matcher)
  );

  // ==========================================================
  // bus address phase capture
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic        acc;
  logic        wr_ctrl;
  logic        wr_rx;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  assign acc = hsel && hready && (htrans == pcb_pkg::HTRANS_NSEQ);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= acc && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  assign wr_ctrl = wr_pend_q && (wr_addr_q == pcb_pkg::OFS_CTRL);
  assign wr_rx   = wr_pend_q && (wr_addr_q == pcb_pkg::OFS_RXBLK);

  // ==========================================================
  // software-held registers
  logic        txchain_q;
  logic [15:0] sw_q;
  logic [7:0]  reqb_q;
  logic [7:0]  sysafi_q;
  logic [63:0] sia_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txchain_q <= 1'b0;
      sw_q      <= pcb_pkg::SW_RST;
      reqb_q    <= 8'h00;
      sysafi_q  <= pcb_pkg::SYSAFI_RST;
      sia_q     <= 64'h0000_0000_0000_0000;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        pcb_pkg::OFS_TXCHAIN: txchain_q <= hwdata[0];
        pcb_pkg::OFS_SW:      sw_q      <= hwdata[15:0];
        pcb_pkg::OFS_REQB:    reqb_q    <= hwdata[7:0];
        pcb_pkg::OFS_SYSAFI:  sysafi_q  <= hwdata[7:0];
        pcb_pkg::OFS_SIA_LO:  sia_q[31:0]  <= hwdata;
        pcb_pkg::OFS_SIA_HI:  sia_q[63:32] <= hwdata;
        default: ;
      endcase
    end
  end

  assign sys.sys_afi  = sysafi_q;
  assign sys.sia      = sia_q;
  assign sys.reqb_afi = reqb_q;

  // ==========================================================
  // protocol state
  pcb_pkg::pcb_state_e state_q;
  pcb_pkg::pcb_rx_e    rx_kind;
  logic                rx_bn;
  logic                rx_chain;
  logic                bn_q;
  logic                rxchain_q;
  logic                sending_q;
  logic                bn_eq;
  logic                live;

  assign rx_kind  = pcb_pkg::pcb_rx_e'(hwdata[pcb_pkg::RX_TYPE_LSB +: pcb_pkg::RX_TYPE_W]);
  assign rx_bn    = hwdata[pcb_pkg::RX_BN];
  assign rx_chain = hwdata[pcb_pkg::RX_CHAIN];
  assign bn_eq    = (rx_bn == bn_q);
  assign live     = wr_rx && (state_q == pcb_pkg::ST_ACTIVE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= pcb_pkg::ST_IDLE;
    end else if (wr_ctrl && hwdata[pcb_pkg::CTRL_FIELDOFF]) begin
      state_q <= pcb_pkg::ST_IDLE;
    end else if (wr_ctrl && hwdata[pcb_pkg::CTRL_ACTIVATE]) begin
      state_q <= pcb_pkg::ST_ACTIVE;
    end else if (live && rx_kind == pcb_pkg::RX_SDESEL) begin
      state_q <= pcb_pkg::ST_DESEL;
    end
  end

  // block number
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bn_q <= pcb_pkg::BN_INIT;
    end else if (wr_ctrl && hwdata[pcb_pkg::CTRL_ACTIVATE]) begin
      bn_q <= pcb_pkg::BN_INIT;
    end else if (live && rx_kind == pcb_pkg::RX_IBLK) begin
      bn_q <= ~bn_q;
    end else if (live && rx_kind == pcb_pkg::RX_RACK && !bn_eq) begin
      bn_q <= ~bn_q;
    end
  end

  // chaining flags: receive side and send side
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxchain_q <= 1'b0;
      sending_q <= 1'b0;
    end else if (wr_ctrl && hwdata[pcb_pkg::CTRL_ACTIVATE]) begin
      rxchain_q <= 1'b0;
      sending_q <= 1'b0;
    end else if (live) begin
      case (rx_kind)
        pcb_pkg::RX_IBLK: begin
          rxchain_q <= rx_chain;
          sending_q <= !rx_chain && txchain_q;
        end
        pcb_pkg::RX_RACK: begin
          if (!bn_eq) begin
            sending_q <= sending_q && txchain_q;
          end
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // reply decision
  pcb_pkg::pcb_rp_e rp_kind_d;
  logic             rp_chain_d;
  pcb_pkg::pcb_rp_e rp_kind_q;
  logic             rp_bn_q;
  logic             rp_chain_q;
  logic             rp_valid_q;
  logic             chaining;

  assign chaining = rxchain_q || sending_q;

  always_comb begin
    rp_kind_d  = pcb_pkg::RP_NONE;
    rp_chain_d = 1'b0;
    case (rx_kind)
      pcb_pkg::RX_IBLK: begin
        if (rx_chain) begin
          rp_kind_d = pcb_pkg::RP_RACK;
        end else begin
          rp_kind_d  = pcb_pkg::RP_IBLK;
          rp_chain_d = txchain_q;
        end
      end
      pcb_pkg::RX_RACK: begin
        rp_kind_d = pcb_pkg::RP_IBLK;
        if (!bn_eq) begin
          rp_chain_d = sending_q && txchain_q;
        end else begin
          rp_chain_d = sending_q;
        end
      end
      pcb_pkg::RX_RNAK: begin
        if (bn_eq) begin
          rp_kind_d  = pcb_pkg::RP_IBLK;
          rp_chain_d = sending_q;
        end else begin
          rp_kind_d = pcb_pkg::RP_RACK;
        end
      end
      pcb_pkg::RX_SDESEL: rp_kind_d = pcb_pkg::RP_SDESEL;
      pcb_pkg::RX_INVALID,
      pcb_pkg::RX_TIMEOUT: begin
        if (chaining) begin
          rp_kind_d = pcb_pkg::RP_RACK;
        end else begin
          rp_kind_d = pcb_pkg::RP_RNAK;
        end
      end
      default: rp_kind_d = pcb_pkg::RP_NONE;
    endcase
  end

  // reply register; a new reply wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rp_kind_q  <= pcb_pkg::RP_NONE;
      rp_bn_q    <= 1'b0;
      rp_chain_q <= 1'b0;
      rp_valid_q <= 1'b0;
    end else if (live && rp_kind_d != pcb_pkg::RP_NONE) begin
      rp_kind_q  <= rp_kind_d;
      rp_bn_q    <= (rx_kind == pcb_pkg::RX_IBLK || (rx_kind == pcb_pkg::RX_RACK && !bn_eq))
                    ? ~bn_q : bn_q;
      rp_chain_q <= rp_chain_d;
      rp_valid_q <= 1'b1;
    end else if (wr_ctrl && (hwdata[pcb_pkg::CTRL_RPLY_CLR] || hwdata[pcb_pkg::CTRL_ACTIVATE])) begin
      rp_valid_q <= 1'b0;
    end
  end

  // ==========================================================
  // read path, data registered in the address phase
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (haddr[7:0])
      pcb_pkg::OFS_REPLY: begin
        rdata_d[2:0]                = rp_kind_q;
        rdata_d[pcb_pkg::RP_BN]     = rp_bn_q;
        rdata_d[pcb_pkg::RP_CHAIN]  = rp_chain_q;
        rdata_d[pcb_pkg::RP_VALID]  = rp_valid_q;
      end
      pcb_pkg::OFS_TXCHAIN: rdata_d[0] = txchain_q;
      pcb_pkg::OFS_SW:      rdata_d[15:0] = sw_q;
      pcb_pkg::OFS_REQB:    rdata_d = {23'h000000, sys.afi_match, reqb_q};
      pcb_pkg::OFS_SYSAFI:  rdata_d[7:0] = sysafi_q;
      pcb_pkg::OFS_SIA_LO:  rdata_d = sia_q[31:0];
      pcb_pkg::OFS_SIA_HI:  rdata_d = sia_q[63:32];
      pcb_pkg::OFS_PUPI:    rdata_d = sys.pupi;
      pcb_pkg::OFS_STATUS: begin
        rdata_d[pcb_pkg::ST_BN]      = bn_q;
        rdata_d[pcb_pkg::ST_RXCHAIN] = rxchain_q;
        rdata_d[pcb_pkg::ST_TXCHAIN] = sending_q;
        rdata_d[pcb_pkg::ST_STATE_LSB +: 2] = state_q;
      end
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (acc && !hwrite) begin
      rdata_q <= rdata_d;
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule : pcb_block_proto

// >>> tb/pcb_checker.sv
// Purpose: bus-side checks of the card block engine
// Assumes: zero wait states, single word transfers
// Notes:   shadows follow block number and system-area writes
`timescale 1ns/1ps
module pcb_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata
);
  // ==========================================================
  // shadow state
  logic        ap_v_q, ap_w_q, bn_q, act_q, got_q, wv;
  logic [7:0]  ap_a_q, afi_q, rq_q;
  logic [31:0] idl_q;
  logic [1:0]  age_q;
  assign wv = ap_v_q && ap_w_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_v_q <= 1'b0;
      ap_w_q <= 1'b0;
      ap_a_q <= 8'h00;
    end else begin
      ap_v_q <= hsel && hready && htrans == pcb_pkg::HTRANS_NSEQ;
      ap_w_q <= hwrite;
      ap_a_q <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bn_q  <= 1'b1;
      act_q <= 1'b0;
      got_q <= 1'b0;
    end else if (wv && ap_a_q == pcb_pkg::OFS_CTRL && hwdata[0]) begin
      bn_q  <= 1'b1;
      act_q <= 1'b1;
      got_q <= 1'b0;
    end else if (wv && ap_a_q == pcb_pkg::OFS_RXBLK && act_q) begin
      got_q <= 1'b1;
      if (hwdata[2:0] == pcb_pkg::RX_IBLK ||
          (hwdata[2:0] == pcb_pkg::RX_RACK && hwdata[4] != bn_q)) bn_q <= ~bn_q;
      if (hwdata[2:0] == pcb_pkg::RX_SDESEL) act_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      afi_q <= 8'h00;
      rq_q  <= 8'h00;
      idl_q <= 32'h0;
      age_q <= 2'd0;
    end else begin
      if (wv && ap_a_q == pcb_pkg::OFS_SYSAFI) afi_q <= hwdata[7:0];
      if (wv && ap_a_q == pcb_pkg::OFS_REQB) rq_q <= hwdata[7:0];
      if (wv && ap_a_q == pcb_pkg::OFS_SIA_LO) idl_q <= hwdata;
      if (wv) age_q <= 2'd0;
      else if (age_q != 2'd3) age_q <= age_q + 2'd1;
    end
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_at(logic [7:0] a);
    ap_v_q && !ap_w_q && ap_a_q == a;
  endsequence
  sequence settled;
    age_q >= 2'd2;
  endsequence

  a_no_unprompted: assert property (rd_at(pcb_pkg::OFS_REPLY) ##0 !got_q |-> !hrdata[8])
    else $error("reply valid before any block");
  a_no_wtx_kind: assert property (rd_at(pcb_pkg::OFS_REPLY) |-> hrdata[2:0] <= 3'h4)
    else $error("reply kind out of range");
  a_reply_bn: assert property (rd_at(pcb_pkg::OFS_REPLY) ##0 hrdata[8] |-> hrdata[4] == bn_q)
    else $error("reply block number wrong");
  a_status_bn: assert property (rd_at(pcb_pkg::OFS_STATUS) |-> hrdata[0] == bn_q)
    else $error("status block number wrong");
  a_afi_stored: assert property (rd_at(pcb_pkg::OFS_SYSAFI) |-> hrdata[7:0] == afi_q)
    else $error("stored family value wrong");
  a_afi_any: assert property (rd_at(pcb_pkg::OFS_REQB) ##0 settled ##0 rq_q == 8'h00 |-> hrdata[8])
    else $error("zero family not answered");
  a_afi_nibble: assert property (rd_at(pcb_pkg::OFS_REQB) ##0 settled ##0
      (rq_q != 8'h00 && (rq_q[3:0] == 4'h0 || rq_q[7:4] == 4'h0)) |-> hrdata[8] ==
      (rq_q[3:0] == 4'h0 ? rq_q[7:4] == afi_q[7:4] : rq_q[3:0] == afi_q[3:0]))
    else $error("nibble family match wrong");
  a_afi_whole: assert property (rd_at(pcb_pkg::OFS_REQB) ##0 settled ##0
      (rq_q[3:0] != 4'h0 && rq_q[7:4] != 4'h0) |-> hrdata[8] == (rq_q == afi_q))
    else $error("whole family match wrong");
  a_pupi_low: assert property (rd_at(pcb_pkg::OFS_PUPI) ##0 settled |-> hrdata == idl_q)
    else $error("identifier not low word");
endmodule : pcb_checker

bind pcb_block_proto pcb_checker i_pcb_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
  .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

// >>> tb/pcb_reader_model.sv
// Purpose: reader side of the block exchange
// Assumes: reply word as read from the card's reply register
// Notes:   next block descriptor is ready one clock after take
`timescale 1ns/1ps
module pcb_reader_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       start,
  input  wire logic       take,
  input  wire logic [8:0] reply,
  output      logic [5:0] nxt
);
  // ==========================================================
  // reader block number and next block
  logic rd_bn_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_bn_q <= 1'b0;
      nxt     <= 6'h00;
    end else if (start) begin
      rd_bn_q <= 1'b0;
      nxt     <= {3'b000, pcb_pkg::RX_IBLK};
    end else if (take) begin
      if (!reply[8]) begin
        nxt <= {3'b000, pcb_pkg::RX_SDESEL};
      end else if (reply[2:0] == pcb_pkg::RP_IBLK) begin
        rd_bn_q <= ~rd_bn_q;
        if (reply[5]) nxt <= {1'b0, ~rd_bn_q, 1'b0, pcb_pkg::RX_RACK};
        else nxt <= {1'b0, ~rd_bn_q, 1'b0, pcb_pkg::RX_IBLK};
      end else if (reply[2:0] == pcb_pkg::RP_RACK) begin
        if (reply[4] != rd_bn_q) begin
          nxt <= {1'b0, rd_bn_q, 1'b0, pcb_pkg::RX_IBLK};
        end else begin
          rd_bn_q <= ~rd_bn_q;
          nxt     <= {1'b0, ~rd_bn_q, 1'b0, pcb_pkg::RX_IBLK};
        end
      end
    end
  end
endmodule : pcb_reader_model

// >>> tb/tb_proximity_card_block_protocol.sv
// Purpose: self-checking bench of the card block engine
// Assumes: one AHB-Lite master, zero wait-state slave
// Notes:   expected words built from field layout
`timescale 1ns/1ps
module tb_proximity_card_block_protocol;
  // ==========================================================
  // signals
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'h2;
  logic        m_start = 1'b0, m_take = 1'b0;
  logic [8:0]  m_rep = 9'h000;
  wire  [5:0]  m_nxt;
  wire         hreadyout, hresp;
  wire  [31:0] hrdata;
  int          errors = 0, n_checks = 0;

  always #5 hclk = ~hclk;

  pcb_block_proto i_pcb_block_proto (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  pcb_reader_model i_pcb_reader_model (.hclk(hclk), .hresetn(hresetn), .start(m_start),
    .take(m_take), .reply(m_rep), .nxt(m_nxt));

  // ==========================================================
  // helpers
  function automatic logic [31:0] rx(input logic [2:0] k, input logic b, input logic c);
    return {26'h0, c, b, 1'b0, k};
  endfunction : rx
  function automatic logic [31:0] rp(input logic [2:0] k, input logic b, input logic c);
    return {23'h0, 1'b1, 2'b00, c, b, 1'b0, k};
  endfunction : rp

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= pcb_pkg::HTRANS_NSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(hrdata, exp);
  endtask : rc

  task automatic feed(input logic [31:0] r);
    m_rep  <= r[8:0];
    m_take <= 1'b1;
    @(posedge hclk);
    m_take <= 1'b0;
    @(posedge hclk);
  endtask : feed

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rc(pcb_pkg::OFS_STATUS, 32'h1);
    rc(pcb_pkg::OFS_SW, {16'h0, pcb_pkg::SW_RST});
    wr(8'hFC, 32'hFFFF_FFFF);
    rc(8'hFC, 32'h0);
    wr(pcb_pkg::OFS_RXBLK, rx(pcb_pkg::RX_IBLK, 1'b0, 1'b0));
    rc(pcb_pkg::OFS_REPLY, 32'h0);
  endtask : t_reset

  task automatic t_rx;
    wr(pcb_pkg::OFS_CTRL, 32'h1);
    wr(pcb_pkg::OFS_RXBLK, rx(pcb_pkg::RX_IBLK, 1'b0, 1'b1));
    rc(pcb_pkg::OFS_REPLY, rp(pcb_pkg::RP_RACK, 1'b0, 1'b0));
    rc(pcb_pkg::OFS_STATUS, 32'h12);
    for (int i = 4; i < 6; i++) begin
      wr(pcb_pkg::OFS_RXBLK, rx(3'(i), 1'b0, 1'b0));
      rc(pcb_pkg::OFS_REPLY, rp(pcb_pkg::RP_RACK, 1'b0, 1'b0));
    end
    wr(pcb_pkg::OFS_RXBLK, rx(pcb_pkg::RX_IBLK, 1'b1, 1'b0));
    rc(pcb_pkg::OFS_REPLY, rp(pcb_pkg::RP_IBLK, 1'b1, 1'b0));
    for (int i = 4; i < 6; i++) begin
      wr(pcb_pkg::OFS_RXBLK, rx(3'(i), 1'b0, 1'b0));
      rc(pcb_pkg::OFS_REPLY, rp(pcb_pkg::RP_RNAK, 1'b1, 1'b0));
    end
  endtask : t_rx

  task automatic t_rblk;
    wr(pcb_pkg::OFS_RXBLK, rx(pcb_pkg::RX_RNAK, 1'b1, 1'b0));
    rc(pcb_pkg::OFS_REPLY, rp(pcb_pkg::RP_IBLK, 1'b1, 1'b0));
    wr(pcb_pkg::OFS_RXBLK, rx(pcb_pkg::RX_RNAK, 1'b0, 1'b0));
    rc(pcb_pkg::OFS_REPLY, rp(pcb_pkg::RP_RACK, 1'b1, 1'b0));
    wr(pcb_pkg::OFS_RXBLK, rx(pcb_pkg::RX_RACK, 1'b1, 1'b0));
    rc(pcb_pkg::OFS_REPLY, rp(pcb_pkg::RP_IBLK, 1'b1, 1'b0));
    wr(pcb_pkg::OFS_RXBLK, rx(pcb_pkg::RX_RACK, 1'b0, 1'b0));
    rc(pcb_pkg::OFS_REPLY, rp(pcb_pkg::RP_IBLK, 1'b0, 1'b0));
  endtask : t_rblk

  task automatic t_chain;
    wr(pcb_pkg::OFS_CTRL, 32'h1);
    wr(pcb_pkg::OFS_TXCHAIN, 32'h1);
    m_start <= 1'b1;
    @(posedge hclk);
    m_start <= 1'b0;
    @(posedge hclk);
    wr(pcb_pkg::OFS_RXBLK, {26'h0, m_nxt});
    rc(pcb_pkg::OFS_REPLY, rp(pcb_pkg::RP_IBLK, 1'b0, 1'b1));
    feed(rp(pcb_pkg::RP_IBLK, 1'b0, 1'b1));
    wr(pcb_pkg::OFS_RXBLK, {26'h0, m_nxt});
    rc(pcb_pkg::OFS_REPLY, rp(pcb_pkg::RP_IBLK, 1'b1, 1'b1));
    rc(pcb_pkg::OFS_STATUS, 32'h15);
    feed(rp(pcb_pkg::RP_IBLK, 1'b1, 1'b1));
    wr(pcb_pkg::OFS_RXBLK, rx(pcb_pkg::RX_INVALID, 1'b0, 1'b0));
    rc(pcb_pkg::OFS_REPLY, rp(pcb_pkg::RP_RACK, 1'b1, 1'b0));
    wr(pcb_pkg::OFS_TXCHAIN, 32'h0);
    wr(pcb_pkg::OFS_RXBLK, {26'h0, m_nxt});
    rc(pcb_pkg::OFS_REPLY, rp(pcb_pkg::RP_IBLK, 1'b0, 1'b0));
  endtask : t_chain

  task automatic t_desel;
    wr(pcb_pkg::OFS_RXBLK, rx(pcb_pkg::RX_SDESEL, 1'b0, 1'b0));
    rc(pcb_pkg::OFS_REPLY, rp(pcb_pkg::RP_SDESEL, 1'b0, 1'b0));
    rc(pcb_pkg::OFS_STATUS, 32'h30);
    wr(pcb_pkg::OFS_RXBLK, rx(pcb_pkg::RX_IBLK, 1'b1, 1'b0));
    rc(pcb_pkg::OFS_REPLY, rp(pcb_pkg::RP_SDESEL, 1'b0, 1'b0));
    wr(pcb_pkg::OFS_CTRL, 32'h4);
    rc(pcb_pkg::OFS_REPLY, 32'h4);
  endtask : t_desel

  task automatic t_afi;
    logic [7:0] v[7] = '{8'h00, 8'h30, 8'h40, 8'h05, 8'h06, 8'h35, 8'h36};
    logic       e[7] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    wr(pcb_pkg::OFS_SYSAFI, 32'h35);
    wr(pcb_pkg::OFS_SIA_LO, 32'hA1B2_C3D4);
    wr(pcb_pkg::OFS_SIA_HI, 32'h1122_3344);
    rc(pcb_pkg::OFS_PUPI, 32'hA1B2_C3D4);
    rc(pcb_pkg::OFS_SYSAFI, 32'h35);
    for (int i = 0; i < 7; i++) begin
      wr(pcb_pkg::OFS_REQB, {24'h0, v[i]});
      repeat (2) @(posedge hclk);
      rc(pcb_pkg::OFS_REQB, {23'h0, e[i], v[i]});
    end
    wr(pcb_pkg::OFS_SW, 32'h6A86);
    rc(pcb_pkg::OFS_SW, 32'h6A86);
  endtask : t_afi

  // ==========================================================
  // run control
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run

  initial begin
    #200000;
    errors++;
    complete_run();
  end

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_rx();
    t_rblk();
    t_chain();
    t_desel();
    t_afi();
    complete_run();
  end
endmodule : tb_proximity_card_block_protocol
